// file: common/vcap_pkg.sv
// Constants shared by the video port capture engine.
// Summary of operation
// - Bytes Cb Y0 Cr Y1 pack into words.
// - Pixel flag high only during active video.
// - Two blanking modes: raw and code-framed.
// - Mode 1 region held in software registers.
// - Mode 1 starts at chosen end code.
// - Mode 1 runs until next start code.
// - Mode 2 starts at chosen start code.
// - Mode 2 ends at chosen end code.
// - Mode 2 byte count per field varies.
// - Vertical scale factor ranges 1 to 31.
// - Scaling drops whole lines, no filtering.
// - Start x00 opens line, end xx1 closes.
// - Bytes sampled on pixel clock into FIFO.
package vcap_pkg;
  // Register port geometry.
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 32;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SCALE = 8'h04;
  localparam logic [7:0] OFS_VBI_START = 8'h08;
  localparam logic [7:0] OFS_VBI_END = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Control register fields.
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned MODE_W = 2;
  localparam int unsigned SCALE_W = 5;
  // Status register fields.
  localparam int unsigned STAT_OVF_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_FIELD_BIT = 2;
  localparam int unsigned STAT_BUSY_BIT = 3;
  localparam int unsigned STAT_LINE_LSB = 16;
  // Capture modes held in the control register.
  localparam logic [1:0] MODE_VIDEO = 2'h0;
  localparam logic [1:0] MODE_VBI_RAW = 2'h1;
  localparam logic [1:0] MODE_VBI_FRAMED = 2'h2;
  // Reset value and lower limit of the scale factor.
  localparam logic [4:0] SCALE_RESET = 5'h01;
  localparam logic [4:0] SCALE_MIN = 5'h01;
  // Embedded timing code preamble and flag positions in the code word.
  localparam logic [7:0] CODE_PRE_FF = 8'hff;
  localparam logic [7:0] CODE_PRE_00 = 8'h00;
  localparam int unsigned XY_F_BIT = 6;
  localparam int unsigned XY_V_BIT = 5;
  localparam int unsigned XY_H_BIT = 4;
  // Bytes per word minus one: the index of the last byte lane.
  localparam logic [1:0] PACK_LAST = 2'h3;
endpackage

// file: rtl/word_fifo.sv
// Word FIFO with a registered output stage between capture and consumer.
module word_fifo
#(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
  logic [AW-1:0] wr_ptr; // Next slot to write.
  logic [AW-1:0] rd_ptr; // Next slot to read.
  logic [AW:0] count; // Words held in storage, not counting the output stage.
  logic push;
  logic pop;

  // Pointers wrap at the depth, which need not be a power of two.
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (count != FULL_COUNT);
  assign push = in_valid && in_ready;
  // Refill the output stage whenever it is empty or being drained.
  assign pop = (count != '0) && (!out_valid || out_ready);

  // Storage write; no reset needed since count guards every read.
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= next_ptr(wr_ptr);
      if (pop)
        rd_ptr <= next_ptr(rd_ptr);
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  // Registered output stage, so the consumer sees flip-flop outputs.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (srst)
    count <= FULL_COUNT) else $error("fifo count above depth");
  a_fifo_refuse: assert property (@(posedge clk) disable iff (srst)
    (in_valid && !in_ready) |=> count == FULL_COUNT || $past(out_ready))
    else $error("fifo refused a word while not full");
endmodule

// file: rtl/video_port_vbi_capture.sv
// Video port capture engine: pin sampling, code parsing, VBI control, scaling, registers.
module video_port_vbi_capture
#(
  parameter int unsigned LINE_W = 10,
  parameter int unsigned FIFO_DEPTH = 8
)
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [vcap_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [vcap_pkg::REG_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [vcap_pkg::REG_DW-1:0] REG_RDATA,
  input wire logic DECODER_PIXEL_CLOCK,
  input wire logic [vcap_pkg::BYTE_W-1:0] VIDEO_BYTE_BUS,
  output logic VALID_PIXEL_FLAG,
  output logic [vcap_pkg::WORD_W-1:0] CAP_DATA,
  output logic CAP_VALID,
  input wire logic CAP_READY
);
  import vcap_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_HUNT, ST_ACTIVE, ST_VBI_RAW, ST_VBI_LINE,
    ST_VBI_GAP} cap_state_t;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  // Software settings.
  logic enable; // Capture engine on.
  logic [MODE_W-1:0] mode; // Video only, raw blanking, or framed blanking.
  logic [SCALE_W-1:0] scale; // Vertical decimation factor as written.
  logic [LINE_W-1:0] vbi_start; // Line whose code opens blanking capture.
  logic [LINE_W-1:0] vbi_end; // Line whose end code closes framed capture.
  logic overflow; // Sticky: a byte was lost because the FIFO was full.

  // Pin sampling.
  logic [1:0] pclk_sync; // Two-stage synchroniser for the pixel clock.
  logic pclk_prev; // Previous synchronised pixel clock level.
  logic [BYTE_W-1:0] bus_meta; // First stage for the byte bus.
  logic [BYTE_W-1:0] bus_sync; // Second stage for the byte bus.
  logic byte_strobe; // One cycle per decoder byte.

  // Code detection pipeline.
  logic [BYTE_W-1:0] pipe [3]; // Last three bytes, pipe[0] newest.
  logic [2:0] pipe_cap; // Capture mark carried with each piped byte.
  logic code_hit; // Fourth byte of a timing code is on the bus.
  logic is_end_code; // The code is an end code.
  logic active_start; // The code opens an active video line.
  logic field_change; // The code carries a new field flag.
  logic field; // Field flag of the last code.

  // Capture control.
  cap_state_t state;
  cap_state_t next_state;
  logic capturing; // Bytes entering the pipeline are to be kept.
  logic vbi_done; // Blanking capture finished for this field.
  logic [LINE_W-1:0] line_num; // End codes seen so far in this field.
  logic [LINE_W-1:0] line_cur; // Line number valid for the current code.
  logic [SCALE_W-1:0] dec_cnt; // Position within the decimation cycle.
  logic [SCALE_W-1:0] dec_cur; // Decimation position for the current code.
  logic [SCALE_W-1:0] scale_eff; // Scale factor with zero taken as one.
  logic keep_line; // The active line under this code survives decimation.
  logic vbi1_start;
  logic vbi2_start;
  logic vbi_finish; // Blanking capture completes on this code.

  // Word packing.
  logic byte_take; // A captured byte leaves the pipeline.
  logic [BYTE_W-1:0] byte_in;
  logic [1:0] pack_cnt; // Bytes held in the packer.
  logic [23:0] pack; // Held bytes, newest at the top.
  logic word_push; // Word waiting for the FIFO.
  logic [WORD_W-1:0] word_data;
  logic fifo_in_ready;

  // Pixel clock and bus each pass two flip-flops before any use.
  // pixel clock sampling
  always_ff @(posedge CLK)
  begin
    pclk_sync <= {pclk_sync[0], DECODER_PIXEL_CLOCK};
    bus_meta <= VIDEO_BYTE_BUS;
    bus_sync <= bus_meta;
  end

  // Edge history; bytes are taken at the falling edge, halfway between the
  // decoder's launch edges, where the bus is settled in the synchronised copy.
  always_ff @(posedge CLK)
  begin
    if (SRST)
      pclk_prev <= 1'b0;
    else
      pclk_prev <= pclk_sync[1];
  end

  assign byte_strobe = pclk_prev && !pclk_sync[1];

  assign code_hit = byte_strobe && (pipe[2] == CODE_PRE_FF) && (pipe[1] == CODE_PRE_00)
    && (pipe[0] == CODE_PRE_00);
  assign is_end_code = bus_sync[XY_H_BIT];
  assign active_start = !bus_sync[XY_H_BIT] && !bus_sync[XY_V_BIT];
  assign field_change = code_hit && (bus_sync[XY_F_BIT] != field);
  assign line_cur = field_change ? '0 : line_num;
  assign dec_cur = field_change ? '0 : dec_cnt;
  assign scale_eff = (scale < SCALE_MIN) ? SCALE_MIN : scale;
  assign keep_line = (dec_cur == '0);
  assign vbi1_start = (mode == MODE_VBI_RAW) && is_end_code && (line_cur == vbi_start)
    && !vbi_done;
  assign vbi2_start = (mode == MODE_VBI_FRAMED) && !is_end_code && (line_cur == vbi_start)
    && !vbi_done;
  assign vbi_finish = code_hit && (((state == ST_VBI_RAW) && !is_end_code)
    || ((state == ST_VBI_LINE) && is_end_code && (line_cur == vbi_end)));
  assign capturing = (state == ST_ACTIVE) || (state == ST_VBI_RAW) || (state == ST_VBI_LINE);
  // Preamble bytes of a code are unmarked here, so codes never reach memory.
  assign byte_take = byte_strobe && !code_hit && pipe_cap[2];
  assign byte_in = pipe[2];

  // Byte pipeline: the three bytes before a code are its preamble, so the
  // capture marks are withheld until the fourth byte settles the question.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pipe[0] <= '0;
      pipe[1] <= '0;
      pipe[2] <= '0;
      pipe_cap <= '0;
    end
    else if (byte_strobe)
    begin
      pipe[0] <= bus_sync;
      pipe[1] <= pipe[0];
      pipe[2] <= pipe[1];
      pipe_cap <= code_hit ? '0 : {pipe_cap[1:0], capturing};
    end
  end

  // Next capture state, decided on each timing code.
  // two blanking modes
  always_comb
  begin
    next_state = state;
    if (!enable)
      next_state = ST_IDLE;
    else if (state == ST_IDLE)
      next_state = ST_HUNT;
    else if (code_hit)
    begin
      unique case (state)
        ST_IDLE, ST_HUNT, ST_ACTIVE:
        begin
          if (vbi1_start)
            next_state = ST_VBI_RAW;
          else if (vbi2_start)
            next_state = ST_VBI_LINE;
          else if (!is_end_code && active_start && keep_line)
            next_state = ST_ACTIVE;
          else
            next_state = ST_HUNT;
        end
        ST_VBI_RAW:
        begin
          if (!is_end_code)
            next_state = (active_start && keep_line) ? ST_ACTIVE : ST_HUNT;
        end
        ST_VBI_LINE:
        begin
          if (is_end_code)
            next_state = (line_cur == vbi_end) ? ST_HUNT : ST_VBI_GAP;
        end
        ST_VBI_GAP:
        begin
          if (!is_end_code)
            next_state = ST_VBI_LINE;
        end
      endcase
    end
  end

  // State register and the pixel flag, which mirrors the active window.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state <= ST_IDLE;
      VALID_PIXEL_FLAG <= 1'b0;
    end
    else
    begin
      state <= next_state;
      VALID_PIXEL_FLAG <= (next_state == ST_ACTIVE);
    end
  end

  // Field tracking, line numbering and the decimation cycle.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      field <= 1'b0;
      line_num <= '0;
      dec_cnt <= '0;
      vbi_done <= 1'b0;
    end
    else if (code_hit)
    begin
      field <= bus_sync[XY_F_BIT];
      line_num <= is_end_code ? line_cur + 1'b1 : line_cur;
      if (!is_end_code && active_start)
        dec_cnt <= (dec_cur >= scale_eff - 1'b1) ? '0 : dec_cur + 1'b1;
      else
        dec_cnt <= dec_cur;
      // Completion wins over the field restart that would clear it.
      if (vbi_finish)
        vbi_done <= 1'b1;
      else if (field_change)
        vbi_done <= 1'b0;
    end
  end

  // Packer: first byte lands in bits 7:0, so a word reads Y1 Cr Y0 Cb from the top.
  // A word that the FIFO cannot yet take holds here and stalls the packer.
  // four bytes per word
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pack <= '0;
      pack_cnt <= '0;
      word_push <= 1'b0;
      word_data <= '0;
    end
    else
    begin
      if (word_push && fifo_in_ready)
        word_push <= 1'b0;
      if (byte_take && !(word_push && !fifo_in_ready))
      begin
        if (pack_cnt == PACK_LAST)
        begin
          word_data <= {byte_in, pack};
          word_push <= 1'b1;
          pack <= '0;
          pack_cnt <= '0;
        end
        else
        begin
          pack <= {byte_in, pack[23:8]};
          pack_cnt <= pack_cnt + 1'b1;
        end
      end
      else if (code_hit && (pack_cnt != '0) && !(word_push && !fifo_in_ready))
      begin
        // A run that stops mid-word is flushed with zero padding above it.
        unique case (pack_cnt)
          2'h1: word_data <= {24'h000000, pack[23:16]};
          2'h2: word_data <= {16'h0000, pack[23:8]};
          default: word_data <= {8'h00, pack};
        endcase
        word_push <= 1'b1;
        pack <= '0;
        pack_cnt <= '0;
      end
    end
  end

  // Captured words queue here; the consumer may stall with CAP_READY.
  // bytes into capture FIFO
  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .srst(SRST),
    .in_data(word_data),
    .in_valid(word_push),
    .in_ready(fifo_in_ready),
    .out_data(CAP_DATA),
    .out_valid(CAP_VALID),
    .out_ready(CAP_READY)
  );

  // Register writes; overflow is write-one-to-clear and a new loss wins.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      enable <= 1'b0;
      mode <= MODE_VIDEO;
      scale <= SCALE_RESET;
      vbi_start <= '0;
      vbi_end <= '0;
      overflow <= 1'b0;
    end
    else
    begin
      if (REG_WR)
      begin
        unique case (REG_ADDR)
          OFS_CTRL:
          begin
            enable <= REG_WDATA[CTRL_EN_BIT];
            mode <= REG_WDATA[CTRL_MODE_LSB +: MODE_W];
          end
          OFS_SCALE: scale <= REG_WDATA[SCALE_W-1:0];
          OFS_VBI_START: vbi_start <= REG_WDATA[LINE_W-1:0];
          OFS_VBI_END: vbi_end <= REG_WDATA[LINE_W-1:0];
          OFS_STATUS:
          begin
            if (REG_WDATA[STAT_OVF_BIT])
              overflow <= 1'b0;
          end
          default:
          begin
          end
        endcase
      end
      // The packer drops every byte while a word is stalled, so any such byte is a loss.
      if (byte_take && word_push && !fifo_in_ready)
        overflow <= 1'b1;
    end
  end

  // Read data stands for the one cycle after the strobe; otherwise zero.
  always_ff @(posedge CLK)
  begin
    if (SRST || !REG_RD)
      REG_RDATA <= '0;
    else
    begin
      REG_RDATA <= '0;
      unique case (REG_ADDR)
        OFS_CTRL:
        begin
          REG_RDATA[CTRL_EN_BIT] <= enable;
          REG_RDATA[CTRL_MODE_LSB +: MODE_W] <= mode;
        end
        OFS_SCALE: REG_RDATA[SCALE_W-1:0] <= scale;
        OFS_VBI_START: REG_RDATA[LINE_W-1:0] <= vbi_start;
        OFS_VBI_END: REG_RDATA[LINE_W-1:0] <= vbi_end;
        OFS_STATUS:
        begin
          REG_RDATA[STAT_OVF_BIT] <= overflow;
          REG_RDATA[STAT_DONE_BIT] <= vbi_done;
          REG_RDATA[STAT_FIELD_BIT] <= field;
          REG_RDATA[STAT_BUSY_BIT] <= capturing;
          REG_RDATA[STAT_LINE_LSB +: LINE_W] <= line_num;
        end
        default:
        begin
        end
      endcase
    end
  end

  // Checks on the capture behaviour.
  sequence s_vbi1_trigger;
    enable && code_hit && vbi1_start && (state inside {ST_HUNT, ST_ACTIVE});
  endsequence
  sequence s_vbi2_close;
    enable && code_hit && (state == ST_VBI_LINE) && is_end_code && (line_cur == vbi_end);
  endsequence

  a_word_order: assert property (
    (byte_take && pack_cnt == PACK_LAST && !word_push)
    |=> word_push && word_data[31:24] == $past(byte_in) && word_data[7:0] == $past(pack[7:0]))
    else $error("word lanes out of order");
  a_flag_window: assert property (
    VALID_PIXEL_FLAG |-> state == ST_ACTIVE && enable)
    else $error("pixel flag outside active window");
  a_raw_begin: assert property (
    s_vbi1_trigger |=> state == ST_VBI_RAW ##1 VALID_PIXEL_FLAG == 1'b0)
    else $error("raw blanking capture did not start");
  a_raw_hold: assert property (
    (enable && state == ST_VBI_RAW && !(code_hit && !is_end_code)) |=> state == ST_VBI_RAW)
    else $error("raw blanking capture broke early");
  a_framed_begin: assert property (
    (enable && code_hit && vbi2_start && state == ST_HUNT) |=> state == ST_VBI_LINE)
    else $error("framed capture did not start");
  a_framed_end: assert property (
    s_vbi2_close |=> state == ST_HUNT && vbi_done)
    else $error("framed capture did not finish");
  a_decim_drop: assert property (
    (enable && code_hit && state == ST_HUNT && !vbi1_start && !vbi2_start && !is_end_code
    && dec_cur != '0) |=> state != ST_ACTIVE)
    else $error("decimated line was captured");
  a_scale_set: assert property (
    (REG_WR && REG_ADDR == OFS_SCALE && REG_WDATA[SCALE_W-1:0] != '0)
    |=> scale_eff == $past(REG_WDATA[SCALE_W-1:0]))
    else $error("scale factor not applied");
  a_decim_wrap: assert property (
    (code_hit && !is_end_code && active_start && dec_cur == scale_eff - 1'b1) |=> dec_cnt == '0)
    else $error("decimation cycle did not wrap");
endmodule

// file: dv/decoder_model.sv
// Behavioural video decoder that streams bytes on a free-running pixel clock.
module decoder_model
(
  output logic pclk,
  output logic [7:0] vbus
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bytes queued by the bench, one sent per pixel clock.
  logic [7:0] q[$];
  // Selects which blanking filler level goes out next.
  logic fill;
  // continuous pixel clock
  // The odd start offset keeps pixel clock edges 0.5 ns ahead of CLK edges, a fixed phase, as 200 ns is eight CLK periods.
  initial
  begin
    pclk = 1'b0;
    vbus = 8'h10;
    fill = 1'b0;
    #37;
    forever #100 pclk = ~pclk;
  end
  // codes from queue
  // Bytes change on the rising edge, so they are stable at the falling sample point.
  // The filler pair never forms a timing code, so idle gaps cannot be mistaken for one.
  always @(posedge pclk)
  begin
    fill <= ~fill;
    if (q.size() > 0)
    begin
      vbus <= q.pop_front();
    end
    else
    begin
      vbus <= fill ? 8'h80 : 8'h10;
    end
  end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the video port capture engine.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vcap_pkg::*;
  typedef logic [7:0] bq_t[$];
  typedef logic [31:0] wq_t[$];
  logic clk;
  logic srst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic pclk;
  logic [7:0] vbus;
  logic vflag;
  logic vflag_d;
  logic [31:0] cap_data;
  logic cap_valid;
  logic cap_ready;
  logic stall;
  int failures;
  int check_count;
  int rises;
  bit cur_f;
  wq_t rx;
  wq_t exp;
  bq_t lb;
  logic [31:0] rd;
  logic [4:0] sc;
  logic [4:0] good[9] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
  decoder_model dec (.pclk(pclk), .vbus(vbus));
  video_port_vbi_capture #(.LINE_W(10), .FIFO_DEPTH(8)) dut (.CLK(clk), .SRST(srst),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .DECODER_PIXEL_CLOCK(pclk), .VIDEO_BYTE_BUS(vbus),
    .VALID_PIXEL_FLAG(vflag), .CAP_DATA(cap_data), .CAP_VALID(cap_valid),
    .CAP_READY(cap_ready));
  // The 25 ns system clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Random back-pressure; words are taken on the handshake edge and flag rises counted.
  always @(posedge clk)
  begin
    cap_ready <= stall ? 1'b0 : 1'($urandom % 2);
    vflag_d <= vflag;
    if (cap_valid === 1'b1 && cap_ready === 1'b1) rx.push_back(cap_data);
    if (vflag === 1'b1 && vflag_d !== 1'b1) rises++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    check_count++;
    if (got !== want)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic reg_expect(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata & mask, w, "register read");
  endtask
  // Code flag byte with its protection bits.
  function automatic logic [7:0] xy(input bit f, input bit v, input bit h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction
  // first byte low
  // A short tail is padded with zero upper bytes.
  function automatic void pack(input bq_t b, ref wq_t w);
    logic [31:0] word;
    for (int i = 0; i < b.size(); i += 4)
    begin
      word = '0;
      for (int k = 0; k < 4; k++)
        if (i + k < b.size()) word[8*k +: 8] = b[i + k];
      w.push_back(word);
    end
  endfunction
  task automatic send_code(input bit v, input bit h);
    dec.q.push_back(CODE_PRE_FF);
    dec.q.push_back(CODE_PRE_00);
    dec.q.push_back(CODE_PRE_00);
    dec.q.push_back(xy(cur_f, v, h));
  endtask
  // Payload avoids the two reserved byte values so no false code appears.
  task automatic send_line(input bit v, input int n, output bq_t b);
    b = {};
    send_code(v, 1'b0);
    repeat (n) b.push_back(8'($urandom_range(254, 1)));
    foreach (b[i]) dec.q.push_back(b[i]);
    send_code(v, 1'b1);
  endtask
  // Waits, bounded, for the decoder queue to run dry, then lets the pipeline drain.
  task automatic settle();
    int t;
    t = 0;
    while (dec.q.size() > 0 && t < 20000)
    begin
      @(posedge clk);
      t++;
    end
    repeat (300) @(posedge clk);
  endtask
  task automatic compare(input string what);
    check(rx.size(), exp.size(), what);
    foreach (exp[i]) if (i < rx.size()) check(rx[i], exp[i], what);
    rx = {};
    exp = {};
  endtask
  // One field of seven active lines; line 1 ends in a partial word.
  task automatic video_field(input int scale, input bit en);
    bq_t b;
    int kept;
    cur_f = ~cur_f;
    rises = 0;
    kept = 0;
    for (int i = 0; i < 7; i++)
    begin
      send_line(1'b0, (i == 1) ? 6 : 4 * (1 + $urandom % 3), b);
      if (en && i % scale == 0)
      begin
        pack(b, exp);
        kept++;
      end
    end
    settle();
    check(rises, kept, "kept lines");
    compare("video words");
    $display("video field done, scale %0d", scale);
  endtask
  // Blanking lines of random length; capture spans lines 2 and 3.
  task automatic framed_field();
    bq_t b;
    cur_f = ~cur_f;
    for (int i = 0; i < 5; i++)
    begin
      send_line(1'b1, 1 + $urandom % 11, b);
      if (i == 2 || i == 3) pack(b, exp);
    end
    settle();
    compare("framed words");
    reg_expect(OFS_STATUS, 32'h2, 32'h2);
    $display("framed field done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog sized well above the roughly 10000 cycles the tests need.
  initial
  begin
    repeat (80000) @(posedge clk);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end
  initial
  begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cap_ready = 1'b0;
    stall = 1'b0;
    vflag_d = 1'b0;
    void'($urandom(32'ha479f23a));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    reg_expect(OFS_CTRL, 32'hffffffff, 32'h0);
    reg_expect(OFS_SCALE, 32'h1f, 32'h01);
    reg_expect(OFS_VBI_END, 32'h3ff, 32'h0);
    reg_expect(8'h14, 32'hffffffff, 32'h0);
    rd = 32'($urandom_range(1023, 0));
    reg_write(OFS_VBI_START, rd);
    reg_expect(OFS_VBI_START, 32'h3ff, rd);
    $display("register test done");
    video_field(1, 1'b0);
    reg_write(OFS_CTRL, {29'h0, MODE_VIDEO, 1'b1});
    reg_write(OFS_SCALE, 32'h0);
    video_field(1, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      sc = (i == 2) ? 5'($urandom_range(31, 1)) : good[$urandom % 9];
      reg_write(OFS_SCALE, {27'h0, sc});
      video_field(int'(sc), 1'b1);
    end
    reg_write(OFS_SCALE, 32'h1f);
    video_field(31, 1'b1);
    // Raw blanking: starts at the first end code, runs through uncoded bytes to the next start.
    reg_write(OFS_VBI_START, 32'h0);
    reg_write(OFS_CTRL, {29'h0, MODE_VBI_RAW, 1'b1});
    cur_f = ~cur_f;
    send_line(1'b1, 5, lb);
    lb = {};
    repeat (9) lb.push_back(8'($urandom_range(254, 1)));
    foreach (lb[i]) dec.q.push_back(lb[i]);
    send_code(1'b1, 1'b0);
    send_code(1'b1, 1'b1);
    pack(lb, exp);
    settle();
    compare("raw words");
    reg_expect(OFS_STATUS, 32'h2, 32'h2);
    $display("raw field done");
    reg_write(OFS_SCALE, 32'h1);
    reg_write(OFS_VBI_START, 32'h2);
    reg_write(OFS_VBI_END, 32'h3);
    reg_write(OFS_CTRL, {29'h0, MODE_VBI_FRAMED, 1'b1});
    framed_field();
    // Fourteen words against a stalled consumer: ten fit, the rest are lost.
    reg_write(OFS_CTRL, {29'h0, MODE_VIDEO, 1'b1});
    stall <= 1'b1;
    cur_f = ~cur_f;
    send_line(1'b0, 56, lb);
    pack(lb, exp);
    settle();
    reg_expect(OFS_STATUS, 32'h1, 32'h1);
    stall <= 1'b0;
    repeat (100) @(posedge clk);
    exp = exp[0:9];
    compare("overflow words");
    reg_write(OFS_STATUS, 32'h1);
    reg_expect(OFS_STATUS, 32'h1, 32'h0);
    $display("overflow test done");
    test_done();
  end
endmodule
